// File: verilog/am_ea_unit.sv
// Operand addressing unit: length decode and effective address formation.
`timescale 1ns/1ps

module am_ea_unit
    import am_pkg::*;
(
    // Clock and reset
    input  wire logic        ref_clk,
    input  wire logic        rst_n,
    // Decoded instruction from the core
    input  wire logic        start,
    input  am_mode_t         mode,
    input  wire logic        use_second_index,
    input  wire logic        rmw_op,
    input  am_inh_op_t       inh_op,
    input  wire logic [7:0]  index_primary,
    input  wire logic [7:0]  index_second,
    // Program and data memory bus
    output logic             mem_rd,
    output logic [15:0]      mem_addr,
    input  wire logic        mem_ack,
    input  wire logic [7:0]  mem_rdata,
    input  wire logic [15:0] pc,
    // Results
    output logic             ea_valid,
    output logic [15:0]      ea_addr,
    output logic [7:0]       imm_value,
    output logic             imm_valid,
    output logic [1:0]       operand_len,
    output logic             mode_illegal,
    output logic [1:0]       int_mask_level,
    output logic             busy
);

    // ------------------------------------------------------------------
    // State machine
    // ------------------------------------------------------------------
    typedef enum logic [2:0] {
        AM_IDLE,
        AM_FETCH_HI,
        AM_FETCH_LO,
        AM_PTR_HI,
        AM_PTR_LO,
        AM_DONE
    } am_state_t;

    am_state_t   state_q, state_d;
    am_mode_t    mode_q, mode_d;
    logic [7:0]  index_q, index_d;
    logic [15:0] word_q, word_d;
    logic [15:0] fetch_pc_q, fetch_pc_d;
    logic        rd_q, rd_d;
    logic [15:0] maddr_q, maddr_d;
    logic        ea_valid_q, ea_valid_d;
    logic [15:0] ea_q, ea_d;
    logic [7:0]  imm_q, imm_d;
    logic        imm_valid_q, imm_valid_d;
    logic [1:0]  len_q, len_d;
    logic        illegal_q, illegal_d;
    logic [1:0]  imask_q, imask_d;

    function automatic logic [1:0] am_len(input am_mode_t m);
        case (m)
            AM_INHERENT, AM_IDX_NONE:               am_len = 2'd0;
            AM_DIR_LONG, AM_IDX_LONG:               am_len = 2'd2;
            default:                                am_len = 2'd1;
        endcase
    endfunction : am_len

    function automatic logic am_is_long(input am_mode_t m);
        am_is_long = (m == AM_DIR_LONG) || (m == AM_IDX_LONG) ||
                     (m == AM_IND_LONG) || (m == AM_INDIDX_LONG);
    endfunction : am_is_long

    // Final address from the collected word; index adds unsigned with carry out of bit 7.
    function automatic logic [15:0] am_final(input am_mode_t m, input logic [15:0] w,
                                             input logic [7:0] ix);
        case (m)
            AM_IDX_NONE:                   am_final = {8'h00, ix};
            AM_IDX_SHORT, AM_INDIDX_SHORT: am_final = {8'h00, w[7:0]} + {8'h00, ix};
            AM_IDX_LONG, AM_INDIDX_LONG:   am_final = w + {8'h00, ix};
            AM_DIR_SHORT, AM_IND_SHORT:    am_final = {8'h00, w[7:0]};
            default:                       am_final = w;
        endcase
    endfunction : am_final

    // ------------------------------------------------------------------
    // Next-state logic
    // ------------------------------------------------------------------
    always_comb begin
        state_d     = state_q;
        mode_d      = mode_q;
        index_d     = index_q;
        word_d      = word_q;
        fetch_pc_d  = fetch_pc_q;
        rd_d        = rd_q;
        maddr_d     = maddr_q;
        ea_valid_d  = 1'b0;
        ea_d        = ea_q;
        imm_d       = imm_q;
        imm_valid_d = 1'b0;
        len_d       = len_q;
        illegal_d   = 1'b0;
        imask_d     = imask_q;
        case (state_q)
            AM_IDLE: begin
                if (start) begin
                    mode_d     = mode;
                    index_d    = use_second_index ? index_second : index_primary;
                    len_d      = am_len(mode);
                    word_d     = AM_ADDR_RESET;
                    fetch_pc_d = pc;
                    if (rmw_op && am_is_long(mode)) begin
                        // Long forms of read-modify-write ops are refused so the core can trap the opcode.
                        illegal_d = 1'b1;
                    end else if (mode == AM_INHERENT) begin
                        if (inh_op == AM_OP_MASK_INT) begin
                            imask_d = AM_IMASK_SET;
                        end else if (inh_op == AM_OP_UNMASK_INT) begin
                            imask_d = AM_IMASK_CLR;
                        end
                        state_d = AM_DONE;
                    end else if (mode == AM_IDX_NONE) begin
                        state_d = AM_DONE;
                    end else if (am_len(mode) == 2'd2) begin
                        rd_d    = 1'b1;
                        maddr_d = pc;
                        state_d = AM_FETCH_HI;
                    end else begin
                        rd_d    = 1'b1;
                        maddr_d = pc;
                        state_d = AM_FETCH_LO;
                    end
                end
            end
            AM_FETCH_HI: begin
                if (mem_ack) begin
                    word_d[15:8] = mem_rdata;
                    maddr_d      = fetch_pc_q + 16'h0001;
                    state_d      = AM_FETCH_LO;
                end
            end
            AM_FETCH_LO: begin
                if (mem_ack) begin
                    word_d[7:0] = mem_rdata;
                    if (mode_q == AM_IMMEDIATE) begin
                        rd_d    = 1'b0;
                        state_d = AM_DONE;
                    end else if (mode_q == AM_IND_LONG || mode_q == AM_INDIDX_LONG) begin
                        maddr_d = {8'h00, mem_rdata};
                        state_d = AM_PTR_HI;
                    end else if (mode_q == AM_IND_SHORT || mode_q == AM_INDIDX_SHORT) begin
                        maddr_d = {8'h00, mem_rdata};
                        state_d = AM_PTR_LO;
                    end else begin
                        rd_d    = 1'b0;
                        state_d = AM_DONE;
                    end
                end
            end
            AM_PTR_HI: begin
                if (mem_ack) begin
                    word_d[15:8] = mem_rdata;
                    maddr_d      = maddr_q + 16'h0001;
                    state_d      = AM_PTR_LO;
                end
            end
            AM_PTR_LO: begin
                if (mem_ack) begin
                    // Short pointers keep a zero high byte.
                    word_d[7:0] = mem_rdata;
                    rd_d        = 1'b0;
                    state_d     = AM_DONE;
                end
            end
            AM_DONE: begin
                if (mode_q == AM_IMMEDIATE) begin
                    imm_d       = word_q[7:0];
                    imm_valid_d = 1'b1;
                end else if (mode_q != AM_INHERENT) begin
                    ea_d       = am_final(mode_q, word_q, index_q);
                    ea_valid_d = 1'b1;
                end
                state_d = AM_IDLE;
            end
            default: begin
                state_d = AM_IDLE;
            end
        endcase
    end

    // ------------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------------
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            state_q     <= AM_IDLE;
            mode_q      <= AM_INHERENT;
            index_q     <= 8'h00;
            word_q      <= AM_ADDR_RESET;
            fetch_pc_q  <= AM_ADDR_RESET;
            rd_q        <= 1'b0;
            maddr_q     <= AM_ADDR_RESET;
            ea_valid_q  <= 1'b0;
            ea_q        <= AM_ADDR_RESET;
            imm_q       <= 8'h00;
            imm_valid_q <= 1'b0;
            len_q       <= AM_LEN_RESET;
            illegal_q   <= 1'b0;
            imask_q     <= AM_IMASK_RST;
        end else begin
            state_q     <= state_d;
            mode_q      <= mode_d;
            index_q     <= index_d;
            word_q      <= word_d;
            fetch_pc_q  <= fetch_pc_d;
            rd_q        <= rd_d;
            maddr_q     <= maddr_d;
            ea_valid_q  <= ea_valid_d;
            ea_q        <= ea_d;
            imm_q       <= imm_d;
            imm_valid_q <= imm_valid_d;
            len_q       <= len_d;
            illegal_q   <= illegal_d;
            imask_q     <= imask_d;
        end
    end

    // Busy is registered as its own flop so it changes with the state.
    logic busy_q;
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            busy_q <= 1'b0;
        end else begin
            busy_q <= (state_d != AM_IDLE);
        end
    end

    assign mem_rd         = rd_q;
    assign mem_addr       = maddr_q;
    assign ea_valid       = ea_valid_q;
    assign ea_addr        = ea_q;
    assign imm_value      = imm_q;
    assign imm_valid      = imm_valid_q;
    assign operand_len    = len_q;
    assign mode_illegal   = illegal_q;
    assign int_mask_level = imask_q;
    assign busy           = busy_q;

endmodule : am_ea_unit

// File: verilog/am_pkg.sv
// Package of constants and types for the operand addressing unit.
package am_pkg;

    // ------------------------------------------------------------------
    // Addressing modes
    // ------------------------------------------------------------------
    typedef enum logic [3:0] {
        AM_INHERENT,
        AM_IMMEDIATE,
        AM_DIR_SHORT,
        AM_DIR_LONG,
        AM_IDX_NONE,
        AM_IDX_SHORT,
        AM_IDX_LONG,
        AM_IND_SHORT,
        AM_IND_LONG,
        AM_INDIDX_SHORT,
        AM_INDIDX_LONG
    } am_mode_t;

    // ------------------------------------------------------------------
    // Inherent operations with side effects
    // ------------------------------------------------------------------
    typedef enum logic [1:0] {
        AM_OP_NONE,
        AM_OP_MASK_INT,
        AM_OP_UNMASK_INT
    } am_inh_op_t;

    // ------------------------------------------------------------------
    // Constants
    // ------------------------------------------------------------------
    localparam logic [15:0] AM_ADDR_RESET = 16'h0000;
    localparam logic [1:0]  AM_IMASK_SET  = 2'h3;
    localparam logic [1:0]  AM_IMASK_CLR  = 2'h0;
    localparam logic [1:0]  AM_IMASK_RST  = 2'h3;
    localparam logic [1:0]  AM_LEN_RESET  = 2'h0;

endpackage : am_pkg

// File: tb/am_mem_model.sv
// Memory model answering the unit's byte reads.
`timescale 1ns/1ps
module am_mem_model (
    // Clock and reset
    input wire logic        ref_clk,
    input wire logic        rst_n,
    // Read bus
    input wire logic        mem_rd,
    input wire logic [15:0] mem_addr,
    input wire logic        slow,
    output logic            mem_ack,
    output logic [7:0]      mem_rdata
);
    logic [1:0] wait_q, wait_d;
    logic       ack_d;
    logic [7:0] pat;
    always_comb begin
        ack_d  = mem_rd && !mem_ack && (!slow || wait_q == 2'h2);
        wait_d = (mem_rd && !ack_d && !mem_ack) ? wait_q + 2'h1 : 2'h0;
        pat    = mem_addr[7:0] ^ mem_addr[15:8] ^ 8'h5a;
    end
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            mem_ack <= 1'b0;
            wait_q  <= 2'h0;
        end else begin
            mem_ack <= ack_d;
            wait_q  <= wait_d;
        end
    end
    // Outside an ack the bus shows the inverse, so stale data never looks right.
    assign mem_rdata = mem_ack ? pat : ~pat;
endmodule : am_mem_model

// File: tb/am_ea_unit_monitor.sv
// Concurrent checks on the operand addressing unit's ports.
`timescale 1ns/1ps
module am_ea_unit_monitor
    import am_pkg::*;
(
    // Request side
    input wire logic        ref_clk,
    input wire logic        rst_n,
    input wire logic        start,
    input am_mode_t         mode,
    input wire logic        use_second_index,
    input wire logic        rmw_op,
    input am_inh_op_t       inh_op,
    input wire logic [7:0]  index_primary,
    input wire logic [7:0]  index_second,
    input wire logic [15:0] pc,
    // Unit outputs
    input wire logic        mem_rd,
    input wire logic [15:0] mem_addr,
    input wire logic        ea_valid,
    input wire logic [15:0] ea_addr,
    input wire logic [1:0]  operand_len,
    input wire logic        mode_illegal,
    input wire logic [1:0]  int_mask_level,
    input wire logic        busy
);
    logic long_m;
    assign long_m = mode inside {AM_DIR_LONG, AM_IDX_LONG, AM_IND_LONG, AM_INDIDX_LONG};
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rst_n);
    sequence s_take;
        start && !busy && !(long_m && rmw_op);
    endsequence
    sequence s_idle2;
        !mem_rd [*2];
    endsequence
    a_inh_quiet: assert property (s_take ##0 mode == AM_INHERENT
        |=> operand_len == 2'h0 ##0 s_idle2) else $error("inherent fetch seen");
    a_imm_fetch: assert property (s_take ##0 mode == AM_IMMEDIATE
        |=> operand_len == 2'h1 && mem_rd && mem_addr == $past(pc)) else $error("imm fetch");
    a_one_byte: assert property (s_take ##0 mode inside {AM_DIR_SHORT, AM_IDX_SHORT,
        AM_IND_SHORT, AM_IND_LONG, AM_INDIDX_SHORT, AM_INDIDX_LONG}
        |=> operand_len == 2'h1 && mem_rd && mem_addr == $past(pc)) else $error("short fetch");
    a_two_byte: assert property (s_take ##0 mode inside {AM_DIR_LONG, AM_IDX_LONG}
        |=> operand_len == 2'h2 && mem_rd && mem_addr == $past(pc)) else $error("long fetch");
    a_idx_base: assert property (s_take ##0 mode == AM_IDX_NONE |=> !mem_rd ##1
        ea_valid && ea_addr == {8'h00, $past(use_second_index, 2) ? $past(index_second, 2)
        : $past(index_primary, 2)}) else $error("index address wrong");
    a_rmw_long: assert property (start && !busy && long_m && rmw_op
        |=> mode_illegal && !mem_rd && !ea_valid) else $error("long rmw accepted");
    a_mask_set: assert property (s_take ##0 mode == AM_INHERENT && inh_op == AM_OP_MASK_INT
        |=> int_mask_level == 2'h3) else $error("mask not set");
    a_mask_clr: assert property (s_take ##0 mode == AM_INHERENT && inh_op == AM_OP_UNMASK_INT
        |=> int_mask_level == 2'h0) else $error("mask not cleared");
    a_level_hold: assert property (!$stable(int_mask_level)
        |-> $past(start && !busy && mode == AM_INHERENT)) else $error("mask level moved");
endmodule : am_ea_unit_monitor
bind am_ea_unit am_ea_unit_monitor u_mon (.ref_clk(ref_clk), .rst_n(rst_n), .start(start),
    .mode(mode), .use_second_index(use_second_index), .rmw_op(rmw_op), .inh_op(inh_op),
    .index_primary(index_primary), .index_second(index_second), .pc(pc), .mem_rd(mem_rd),
    .mem_addr(mem_addr), .ea_valid(ea_valid), .ea_addr(ea_addr), .operand_len(operand_len),
    .mode_illegal(mode_illegal), .int_mask_level(int_mask_level), .busy(busy));

// File: tb/am_ea_unit_tb_top.sv
// Self-checking testbench of the operand addressing unit.
`timescale 1ns/1ps
module am_ea_unit_tb_top import am_pkg::*; ;
    logic        ref_clk, rst_n, start, usi, rmw, slow, mrd, ack, eav, immv, ill, busy;
    am_mode_t    mode;
    am_inh_op_t  op;
    logic [7:0]  ixp, ixs, rdata, imm;
    logic [15:0] pc, maddr, ea;
    logic [1:0]  len, lvl;
    logic [15:0] q_ea[$];
    logic [7:0]  q_imm[$];
    int          n_errors = 0, check_count = 0, seed = 32'hf95fabba;
    am_ea_unit DUT (.ref_clk(ref_clk), .rst_n(rst_n), .start(start), .mode(mode),
        .use_second_index(usi), .rmw_op(rmw), .inh_op(op), .index_primary(ixp),
        .index_second(ixs), .mem_rd(mrd), .mem_addr(maddr), .mem_ack(ack), .mem_rdata(rdata),
        .pc(pc), .ea_valid(eav), .ea_addr(ea), .imm_value(imm), .imm_valid(immv),
        .operand_len(len), .mode_illegal(ill), .int_mask_level(lvl), .busy(busy));
    am_mem_model u_mem (.ref_clk(ref_clk), .rst_n(rst_n), .mem_rd(mrd), .mem_addr(maddr),
        .slow(slow), .mem_ack(ack), .mem_rdata(rdata));
    initial begin
        ref_clk = 1'b0;
        forever #12.5 ref_clk = ~ref_clk;
    end
    task automatic cmp_val(input logic [15:0] exp, input logic [15:0] act);
        check_count++;
        if (act !== exp) begin
            n_errors++;
            $display("BAD t=%0t exp=%h got=%h", $time, exp, act);
        end
    endtask : cmp_val
    task automatic test_done;
        $display("checks=%0d mismatches=%0d", check_count, n_errors);
        if (n_errors == 0 && check_count > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : test_done
    function automatic logic [7:0] fm(input logic [15:0] a);
        return a[7:0] ^ a[15:8] ^ 8'h5a;
    endfunction : fm
    // A result with no note queued compares against unknown and so always fails.
    always @(posedge ref_clk) begin
        if (eav === 1'b1) begin
            cmp_val(q_ea.size() > 0 ? q_ea.pop_front() : 16'hxxxx, ea);
        end
        if (immv === 1'b1) begin
            cmp_val(q_imm.size() > 0 ? {8'h00, q_imm.pop_front()} : 16'hxxxx, {8'h00, imm});
        end
    end
    task automatic run(input am_mode_t m, input logic r, input am_inh_op_t o);
        logic [15:0] ix, p, w, lw;
        logic [1:0]  el;
        logic        lg;
        int          n;
        mode = m;
        rmw = r;
        op = o;
        usi = $random(seed);
        ixp = $random(seed);
        ixs = $random(seed);
        pc = $random(seed);
        slow = $random(seed);
        start = 1'b1;
        ix = {8'h00, usi ? ixs : ixp};
        p = {8'h00, fm(pc)};
        lw = {fm(pc), fm(pc + 16'h0001)};
        lg = m inside {AM_DIR_LONG, AM_IDX_LONG, AM_IND_LONG, AM_INDIDX_LONG};
        w = (m inside {AM_IND_LONG, AM_INDIDX_LONG}) ? {fm(p), fm(p + 16'h0001)} : {8'h00, fm(p)};
        el = (m inside {AM_INHERENT, AM_IDX_NONE}) ? 2'h0 : (m inside {AM_DIR_LONG, AM_IDX_LONG}) ? 2'h2 : 2'h1;
        if (!(lg && r)) begin
            case (m)
                AM_IMMEDIATE: q_imm.push_back(fm(pc));
                AM_DIR_SHORT: q_ea.push_back(p);
                AM_DIR_LONG: q_ea.push_back(lw);
                AM_IDX_NONE: q_ea.push_back(ix);
                AM_IDX_SHORT: q_ea.push_back(ix + p);
                AM_IDX_LONG: q_ea.push_back(lw + ix);
                AM_IND_SHORT, AM_IND_LONG: q_ea.push_back(w);
                AM_INDIDX_SHORT, AM_INDIDX_LONG: q_ea.push_back(w + ix);
                default: ;
            endcase
        end
        @(posedge ref_clk);
        #2;
        start = 1'b0;
        if (lg && r) begin
            cmp_val(16'h0001, {15'h0, ill});
        end else begin
            cmp_val({14'h0, el}, {14'h0, len});
            start = (busy === 1'b1);
        end
        n = 0;
        do begin
            @(posedge ref_clk);
            #2;
            start = 1'b0;
            n++;
        end while (busy !== 1'b0 && n < 40);
        if (m == AM_INHERENT && o != AM_OP_NONE) begin
            cmp_val(o == AM_OP_MASK_INT ? 16'h0003 : 16'h0000, {14'h0, lvl});
        end
        $display("mode %0d rmw %0d done", m, r);
    endtask : run
    initial begin
        #300000;
        n_errors++;
        test_done();
    end
    initial begin
        {rst_n, start, usi, rmw, slow, ixp, ixs, pc} = '0;
        mode = AM_INHERENT;
        op = AM_OP_NONE;
        repeat (8) @(posedge ref_clk);
        #2;
        rst_n = 1'b1;
        cmp_val(16'h0003, {14'h0, lvl});
        for (int k = 0; k < 88; k++) begin
            run(am_mode_t'(k % 11), (k / 11) % 2 == 1, am_inh_op_t'((k / 11) % 3));
        end
        repeat (4) @(posedge ref_clk);
        test_done();
    end
endmodule : am_ea_unit_tb_top
